/* rtl/timer_pkg.sv */
package timer_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMER_COUNT  = 8'h01;
    localparam logic [7:0] IDX_INT_CONTROL  = 8'h0b;
    localparam logic [7:0] IDX_OPTION       = 8'h81;
    localparam logic [7:0] IDX_PORT_A_DIR   = 8'h85;
    localparam logic [7:0] IDX_WDT_COMMAND  = 8'h90;
    localparam logic [7:0] IDX_UNIT_STATUS  = 8'h91;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int GIE_BIT        = 7;
    localparam int OVF_ENABLE_BIT = 5;
    localparam int OVF_FLAG_BIT   = 2;
    localparam int CS_BIT         = 5;
    localparam int EDGE_BIT       = 4;
    localparam int ASSIGN_BIT     = 3;
    localparam int RATIO_LSB      = 0;
    localparam int RATIO_W        = 3;
    localparam int WDT_CLEAR_BIT  = 0;
    localparam int PORT_A_W       = 5;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]          TIMER_RST  = 8'h00;
    localparam logic [7:0]          INTERRUPT_CONTROL_RST = 8'h00;
    localparam logic [7:0]          OPTION_RST = 8'hff;
    localparam logic [PORT_A_W-1:0] PORTA_RST  = 5'h1f;

    ////////////////////////////////////////////////////////////////////////////
    // timing: four pclk phases make one instruction cycle
    localparam logic [1:0] PHASE_Q2       = 2'h1;
    localparam logic [1:0] PHASE_Q4       = 2'h3;
    localparam logic [1:0] WRITE_INHIBIT  = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // whole state of the unit
    typedef struct packed {
        logic [7:0]          timer;
        logic [7:0]          interrupt_control;
        logic [7:0]          option;
        logic [PORT_A_W-1:0] port_a;
        logic [7:0]          divider;
        logic [1:0]          phase;
        logic                sync1;
        logic                sync2;
        logic                ext_prev;
        logic                sample;
        logic [1:0]          inhibit;
        logic [31:0]         rdata;
        logic                wdt_tick_out;
        logic                wdt_clr_out;
    } unit_state_t;

endpackage : timer_pkg

/* rtl/timer_prescaler_unit.sv */
`timescale 1ns/1ps

module timer_prescaler_unit (
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // core side
    input  wire logic        sleep_mode,
    input  wire logic        wdt_osc_tick,
    output logic             timer_irq,
    output logic             wdt_scaled_tick,
    output logic             wdt_clear,
    output logic [4:0]       port_a_dir,
    // pin
    input  wire logic        external_count_input
);

    timer_pkg::unit_state_t s_q;
    timer_pkg::unit_state_t s_d;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic       setup;
    logic       access;
    logic [7:0] idx;
    logic       mapped;
    logic       wr;

    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign idx    = paddr[9:2];
    assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                    ((idx == timer_pkg::IDX_TIMER_COUNT) ||
                     (idx == timer_pkg::IDX_INT_CONTROL) ||
                     (idx == timer_pkg::IDX_OPTION) ||
                     (idx == timer_pkg::IDX_PORT_A_DIR) ||
                     (idx == timer_pkg::IDX_WDT_COMMAND) ||
                     (idx == timer_pkg::IDX_UNIT_STATUS));
    assign wr     = clk_en & access & pwrite & mapped;

    // read data is latched in setup, so the access phase waits only while clk_en is low
    assign pready  = clk_en;
    assign pslverr = access & ~mapped;
    assign prdata  = s_q.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // option fields
    logic                            to_wdt;
    logic                            ext_mode;
    logic                            fall_edge;
    logic [timer_pkg::RATIO_W-1:0]   ratio;

    assign to_wdt    = s_q.option[timer_pkg::ASSIGN_BIT];
    assign ext_mode  = s_q.option[timer_pkg::CS_BIT];
    assign fall_edge = s_q.option[timer_pkg::EDGE_BIT];
    assign ratio     = s_q.option[timer_pkg::RATIO_LSB +: timer_pkg::RATIO_W];

    ////////////////////////////////////////////////////////////////////////////
    // outputs from flops
    assign timer_irq = s_q.interrupt_control[timer_pkg::OVF_FLAG_BIT] &
                       s_q.interrupt_control[timer_pkg::OVF_ENABLE_BIT] &
                       s_q.interrupt_control[timer_pkg::GIE_BIT];
    assign wdt_scaled_tick = s_q.wdt_tick_out;
    assign wdt_clear       = s_q.wdt_clr_out;
    assign port_a_dir      = s_q.port_a;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic       ext_level;
        logic       ext_rise;
        logic       inst_tick;
        logic       src_event;
        logic [7:0] div_next;
        logic       div_rise;
        logic       pres_level;
        logic       sample_pt;
        logic       timer_inc;
        logic       tmr_wr;
        logic       wdt_clr;
        logic       run;
        logic       ovf_set;
        ext_level  = 1'b0;
        ovf_set    = 1'b0;
        ext_rise   = 1'b0;
        inst_tick  = 1'b0;
        src_event  = 1'b0;
        div_next   = 8'h00;
        div_rise   = 1'b0;
        pres_level = 1'b0;
        sample_pt  = 1'b0;
        timer_inc  = 1'b0;
        tmr_wr     = 1'b0;
        wdt_clr    = 1'b0;
        run        = 1'b0;
        s_d        = s_q;

        // pulses last one cycle
        s_d.wdt_tick_out = 1'b0;
        s_d.wdt_clr_out  = 1'b0;

        // pin passes two flops before any logic reads it
        s_d.sync1 = external_count_input;
        s_d.sync2 = s_q.sync1;

        // instruction phase clocks
        s_d.phase = s_q.phase + 2'h1;
        run       = ~sleep_mode;
        inst_tick = (s_q.phase == timer_pkg::PHASE_Q4);

        // edge select inverts the pin so rising always counts
        ext_level = s_q.sync2 ^ fall_edge;
        s_d.ext_prev = ext_level;
        ext_rise  = ext_level & ~s_q.ext_prev;

        // clock event feeding the timer path
        src_event = ext_mode ? ext_rise :
                    (inst_tick & (s_q.inhibit == 2'h0));

        // divider: counts the selected source of its owner
        div_next = s_q.divider + 8'h01;
        div_rise = ~s_q.divider[ratio] & div_next[ratio];
        if (run) begin
            if (!to_wdt && src_event) begin
                s_d.divider = div_next;
            end
            if (to_wdt && wdt_osc_tick) begin
                s_d.divider = div_next;
            end
        end

        // watchdog side: scaled only while it owns the divider
        if (to_wdt) begin
            s_d.wdt_tick_out = run & wdt_osc_tick & div_rise;
        end else begin
            s_d.wdt_tick_out = wdt_osc_tick;
        end

        // divider output level, or the pin level while the watchdog owns the divider; bit n toggles each 2^n source events
        pres_level = to_wdt ? ext_level : s_q.divider[ratio];

        // counter mode: output sampled on Q2 and Q4
        sample_pt = (s_q.phase == timer_pkg::PHASE_Q2) ||
                    (s_q.phase == timer_pkg::PHASE_Q4);
        if (sample_pt) begin
            s_d.sample = pres_level;
        end

        // increment decision
        if (ext_mode) begin
            timer_inc = sample_pt & pres_level & ~s_q.sample;
        end else if (to_wdt) begin
            timer_inc = src_event;
        end else begin
            timer_inc = src_event & div_rise;
        end
        timer_inc = timer_inc & run;

        // write inhibit runs down on instruction boundaries
        if (inst_tick && (s_q.inhibit != 2'h0)) begin
            s_d.inhibit = s_q.inhibit - 2'h1;
        end

        if (timer_inc) begin
            s_d.timer = s_q.timer + 8'h01;
            if (s_q.timer == 8'hff) begin
                s_d.interrupt_control[timer_pkg::OVF_FLAG_BIT] = 1'b1;
                ovf_set = 1'b1;
            end
        end

        // register writes; divider itself is never addressed
        tmr_wr  = wr && (idx == timer_pkg::IDX_TIMER_COUNT);
        wdt_clr = wr && (idx == timer_pkg::IDX_WDT_COMMAND) &&
                  pwdata[timer_pkg::WDT_CLEAR_BIT];
        if (tmr_wr) begin
            s_d.timer   = pwdata[7:0];
            s_d.inhibit = timer_pkg::WRITE_INHIBIT;
            if (!to_wdt) begin
                s_d.divider = 8'h00;
            end
        end
        if (wdt_clr) begin
            s_d.wdt_clr_out = 1'b1;
            if (to_wdt) begin
                s_d.divider = 8'h00;
            end
        end
        if (wr && (idx == timer_pkg::IDX_INT_CONTROL)) begin
            // only a set in this very cycle beats the software clear
            s_d.interrupt_control = pwdata[7:0] |
                         ({7'h00, ovf_set} << timer_pkg::OVF_FLAG_BIT);
        end
        if (wr && (idx == timer_pkg::IDX_OPTION)) begin
            // takes effect at once, no halt needed
            s_d.option = pwdata[7:0];
        end
        if (wr && (idx == timer_pkg::IDX_PORT_A_DIR)) begin
            s_d.port_a = pwdata[timer_pkg::PORT_A_W-1:0];
        end

        // read data captured in setup phase
        if (clk_en && setup && !pwrite) begin
            // unmapped or misaligned reads fall to the zero default
            case (mapped ? idx : 8'h00)
                timer_pkg::IDX_TIMER_COUNT: s_d.rdata = {24'h0, s_q.timer};
                timer_pkg::IDX_INT_CONTROL: s_d.rdata = {24'h0, s_q.interrupt_control};
                timer_pkg::IDX_OPTION:      s_d.rdata = {24'h0, s_q.option};
                timer_pkg::IDX_PORT_A_DIR:  s_d.rdata = {27'h0, s_q.port_a};
                timer_pkg::IDX_UNIT_STATUS: s_d.rdata = {28'h0, s_q.inhibit,
                                                         s_q.sample, sleep_mode};
                default:                    s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; clock enable freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q              <= '0;
            s_q.timer        <= timer_pkg::TIMER_RST;
            s_q.interrupt_control       <= timer_pkg::INTERRUPT_CONTROL_RST;
            s_q.option       <= timer_pkg::OPTION_RST;
            s_q.port_a       <= timer_pkg::PORTA_RST;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

endmodule : timer_prescaler_unit

/* verification/timer_prescaler_unit_chk.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module timer_prescaler_unit_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // bus
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // core side
    input wire logic        wdt_osc_tick,
    input wire logic        timer_irq,
    input wire logic        wdt_scaled_tick,
    input wire logic        wdt_clear,
    input wire logic [4:0]  port_a_dir
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic ok_addr, wr, clr_wr, en_q;
    // misaligned or out-of-map addresses count as unmapped
    assign ok_addr = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 &&
        paddr[9:2] inside {8'h01, 8'h0b, 8'h81, 8'h85, 8'h90, 8'h91};
    assign wr = psel && penable && pready && pwrite && ok_addr;
    assign clr_wr = wr && paddr[9:2] == 8'h90 && pwdata[0];
    // shadow of both enables; only the flag is set by hardware
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
        end else if (wr && paddr[9:2] == 8'h0b) begin
            en_q <= pwdata[5] && pwdata[7];
        end
    end
    sequence one_pulse;
        wdt_clear ##1 !wdt_clear;
    endsequence
    a_ready_tracks_en: assert property (pready == clk_en) else $error("pready wrong");
    a_error_unmapped: assert property (psel && penable && !ok_addr |-> pslverr)
        else $error("no error on unmapped access");
    a_error_mapped: assert property (psel && penable && ok_addr |-> !pslverr)
        else $error("error on mapped access");
    a_unmapped_reads_zero: assert property (psel && penable && !pwrite && !ok_addr
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_irq_masked: assert property (!en_q |-> !timer_irq)
        else $error("request while masked");
    a_clear_pulse: assert property (clr_wr |=> one_pulse)
        else $error("clear pulse missing");
    a_clear_cause: assert property (wdt_clear |-> $past(clr_wr))
        else $error("clear pulse without command");
    a_port_loads: assert property (wr && paddr[9:2] == 8'h85
        |=> port_a_dir == $past(pwdata[4:0])) else $error("direction not loaded");
    a_tick_cause: assert property (wdt_scaled_tick |-> $past(wdt_osc_tick))
        else $error("watchdog tick without source");
endmodule : timer_prescaler_unit_chk

bind timer_prescaler_unit timer_prescaler_unit_chk timer_prescaler_unit_chk_inst (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .wdt_osc_tick, .timer_irq, .wdt_scaled_tick, .wdt_clear,
    .port_a_dir
);

/* verification/count_source.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module count_source (
    // timing reference
    input wire logic pclk,
    // count pin
    output logic     level
);
    // pin rests low between bursts
    initial level = 1'b0;
    // eight pclk per phase, well above the sync minimum
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (8) @(posedge pclk);
            level <= 1'b1;
            repeat (8) @(posedge pclk);
            level <= 1'b0;
        end
    endtask : pulses
endmodule : count_source

/* verification/tb_timer_prescaler_unit.sv */
`timescale 1ns/1ps
module tb_timer_prescaler_unit;
    logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, pin;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_v;
    logic        pready, pslverr, er_v, sleep_mode = 1'b0, wdt_osc_tick = 1'b0;
    logic        timer_irq, wdt_scaled_tick, wdt_clear;
    logic [4:0]  port_a_dir;
    logic [7:0]  a;
    int          fails = 0, total_checks = 0, cycles = 0, ticks = 0;

    always #12.5 pclk = ~pclk;

    timer_prescaler_unit timer_prescaler_unit_inst (.pclk, .presetn, .clk_en, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .sleep_mode,
        .wdt_osc_tick, .timer_irq, .wdt_scaled_tick, .wdt_clear, .port_a_dir,
        .external_count_input(pin));
    count_source count_source_inst (.pclk, .level(pin));

    // count watchdog pulses and cut a hang short
    always @(posedge pclk) begin
        cycles++;
        if (wdt_scaled_tick === 1'b1) ticks++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] ad, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        bus(1'b1, {2'h0, i, 2'h0}, d);
    endtask : wr
    task automatic rd(input logic [7:0] i);
        bus(1'b0, {2'h0, i, 2'h0}, 8'h00);
    endtask : rd
    task automatic gap(input int n);
        repeat (n) @(posedge pclk);
    endtask : gap
    // two timer reads n pclk apart, same phase, so the difference is exact
    task automatic span(input int n);
        gap(16);
        rd(8'h01);
        a = rd_v[7:0];
        gap(n - 3);
        rd(8'h01);
    endtask : span
    task automatic to_wdt(input logic [7:0] o);
        wr(8'h01, 8'h00);
        wr(8'h90, 8'h01);
        wr(8'h81, o);
    endtask : to_wdt
    task automatic to_timer(input logic [7:0] o);
        wr(8'h90, 8'h01);
        wr(8'h81, o);
    endtask : to_timer
    task automatic osc(input int n);
        repeat (n) begin
            @(posedge pclk);
            wdt_osc_tick <= 1'b1;
            @(posedge pclk);
            wdt_osc_tick <= 1'b0;
            gap(6);
        end
    endtask : osc
    task automatic tally_and_finish();
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h81);
        chk("option", rd_v, 32'hff);
        rd(8'h0b);
        chk("interrupt_control", rd_v, 32'h00);
        bus(1'b0, 12'h3fc, 8'h00);
        chk("slverr", er_v, 32'h1);
        wr(8'h85, 8'h0a);
        rd(8'h85);
        chk("port dir", rd_v, 32'h0a);
        // internal clock, divider on the watchdog
        to_wdt(8'h08);
        wr(8'h01, 8'hfd);
        wr(8'h0b, 8'h00);
        gap(40);
        rd(8'h0b);
        chk("overflow flag", rd_v, 32'h04);
        chk("masked irq", timer_irq, 32'h0);
        wr(8'h0b, 8'ha4);
        gap(2);
        chk("irq", timer_irq, 32'h1);
        wr(8'h0b, 8'h80);
        gap(2);
        chk("irq cleared", timer_irq, 32'h0);
        wr(8'h01, 8'h40);
        rd(8'h01);
        chk("timer hold", rd_v, 32'h40);
        span(64);
        chk("timer rate", rd_v[7:0] - a, 32'h10);
        sleep_mode <= 1'b1;
        wr(8'h01, 8'h20);
        span(64);
        chk("sleep hold", rd_v, 32'h20);
        sleep_mode <= 1'b0;
        // every ratio code with the divider on the timer
        to_timer(8'h00);
        for (int n = 0; n < 8; n++) begin
            wr(8'h81, n[7:0]);
            wr(8'h01, 8'h00);
            span(16 << (n + 1));
            chk("scaled rate", rd_v[7:0] - a, 32'h4);
        end
        ticks = 0;
        osc(5);
        chk("wdt ticks", ticks, 32'h5);
        // external pin; edge change can fake one event, so settle then load
        to_wdt(8'h28);
        wr(8'h01, 8'h00);
        gap(16);
        count_source_inst.pulses(5);
        gap(16);
        rd(8'h01);
        chk("rising count", rd_v, 32'h5);
        // divider on the watchdog at 1:2, cleared by the switch sequence
        ticks = 0;
        osc(4);
        chk("scaled wdt ticks", ticks, 32'h2);
        wr(8'h81, 8'h38);
        gap(16);
        wr(8'h01, 8'h00);
        gap(16);
        count_source_inst.pulses(3);
        gap(16);
        rd(8'h01);
        chk("falling count", rd_v, 32'h3);
        to_timer(8'h20);
        wr(8'h01, 8'h00);
        gap(16);
        count_source_inst.pulses(8);
        gap(16);
        rd(8'h01);
        chk("divided count", rd_v, 32'h4);
        tally_and_finish();
    end
endmodule : tb_timer_prescaler_unit
